//--- core/dcpt_pkg.sv
`default_nettype none
package dcpt_pkg;
  // register bank offsets
  localparam logic [3:0] ADDR_SHORT_CTL = 4'h0;
  localparam logic [3:0] ADDR_SHARED_CTL = 4'h1;
  localparam logic [3:0] ADDR_LONG_CTL = 4'h2;
  localparam logic [3:0] ADDR_RUN_SYNC = 4'h3;
  localparam logic [3:0] ADDR_SHORT_LO = 4'h4;
  localparam logic [3:0] ADDR_SHORT_HI = 4'h5;
  localparam logic [3:0] ADDR_LONG_LO = 4'h6;
  localparam logic [3:0] ADDR_LONG_HI = 4'h7;
  localparam logic [3:0] ADDR_CAPT_LO = 4'h8;
  localparam logic [3:0] ADDR_CAPT_HI = 4'h9;
  // control field positions
  localparam int BIT_RUN = 7;
  localparam int BIT_SINGLE = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_PRESC_HI = 4;
  localparam int BIT_PRESC_LO = 3;
  localparam int BIT_CAPIE = 2;
  localparam int BIT_TCIE = 1;
  localparam int BIT_SYNC = 2;
  localparam int BIT_RS_SHORT = 1;
  localparam int BIT_RS_LONG = 0;
  localparam int BIT_SHORT_INIT = 1;
  localparam int BIT_LONG_INIT = 0;
  // shared control: mode field 3:2, edge field 5:4
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PINGPONG = 2'h1;
  localparam logic [4:0] RSV_ONES = 5'h1F;
  // reset and wrap values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] WRAP_WORD = 16'hFFFF;
endpackage : dcpt_pkg
`default_nettype wire

//--- core/dcpt_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
// divides the system clock by 1, 2, 4 or 8 into a one-cycle tick
module dcpt_prescaler #(
  parameter int DIV_W = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic [1:0] sel_i,
  input wire logic restart_i,
  // tick out
  output logic tick_o
);
  import dcpt_pkg::*;

  if (DIV_W < 3) begin : g_div_check
    $error("dcpt_prescaler: DIV_W must reach divide by 8");
  end

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  wire [DIV_W-1:0] div_mask = DIV_W'((1 << sel_i) - 1);

  // restart aligns the first tick to the counter start
  assign div_nxt = (restart_i || ((div_r & div_mask) == div_mask)) ? '0 : div_r + 1'b1;
  assign tick_o = !restart_i && ((div_r & div_mask) == div_mask);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // a tick halfway through the period would betray a divide by 4, 2 or 1
  a_div_eight: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE2
    tick_o && sel_i == 2'h3 ##1 (!restart_i && sel_i == 2'h3) [*8]
      |-> tick_o && !$past(tick_o, 4))
    else $error("divide by 8 tick period wrong");
endmodule // dcpt_prescaler
`default_nettype wire

//--- core/dcpt_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE1: short control bit 2 enables the capture interrupt.
// RULE2: short control bits 4:3 divide the count clock by 1, 2, 4 or 8.
// RULE3: long single-pass capture ignores later input edges and keeps counting down.
// RULE4: then each short timeout captures long count without reload, capture interrupt optional.
// RULE5: writing long single-pass 0 then 1 re-arms one capture-and-reload edge.
// RULE6: long counter wraps from zero to all ones, sets status, optional interrupt.
// RULE7: software uses ping-pong only in transmit, both single-pass, mode bits set.
// RULE8: ping-pong short start takes shared bit 1 level and matching hold value.
// RULE9: short terminal count in ping-pong stops short, starts long with level.
// RULE10: long terminal count in ping-pong stops long and restarts short.
// RULE11: each counter raises terminal-count interrupt when its control bit 1 is set.
// RULE12: writing 00 to shared bits 3:2 ends ping-pong.
// RULE13: software stops counters and clears flags before selecting ping-pong.
// RULE14: software never programs initial count 1 for ping-pong.
// RULE15: restarting a counter reloads its programmed initial value.
// RULE16: sync mode aligns first short pulse to the demodulated input.
// RULE17: run/sync reserved bits ignore writes and read as ones.
// RULE18: sync bit resets to disabled and survives stop-mode recovery.
// RULE19: long interrupt is request 3, short interrupt is request 4.
// RULE20: short high and low hold values live at offsets 05h and 04h.
// RULE21: short bit 6 picks modulo-N or single pass; single pass stops.
// RULE22: short bit 5 flags timeout; writing 1 clears, 0 does nothing.
// RULE23: short bit 7 shows and controls run; resets to 0.
module dcpt_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register bank port
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // carrier pins
  input wire logic demod_in_i,
  output logic short_output_pin_o,
  output logic long_output_pin_o,
  // interrupt requests
  output logic long_counter_irq_o,
  output logic short_counter_irq_o
);
  import dcpt_pkg::*;

  // register bank
  logic sc_single_r, sc_capie_r, sc_tcie_r, short_run_r, short_to_r;
  logic [1:0] sc_presc_r;
  logic [5:0] shared_r;
  logic lc_single_r, lc_capie_r, lc_toie_r, long_run_r, long_to_r;
  logic sync_r;
  logic [7:0] short_high_hold_r, short_low_hold_r, long_high_hold_r, long_low_hold_r;
  logic [15:0] long_cap_r;
  // counting state
  logic [7:0] short_cnt_r;
  logic [15:0] long_cnt_r;
  logic short_out_r, long_out_r, short_wait_r, long_armed_r;
  logic dm_s1_r, dm_s2_r, dm_prev_r;
  logic short_irq_r, long_irq_r;
  logic [7:0] rdata_r;

  // write decode
  wire wr_sc = reg_wr_i && reg_addr_i == ADDR_SHORT_CTL;
  wire wr_sh = reg_wr_i && reg_addr_i == ADDR_SHARED_CTL;
  wire wr_lc = reg_wr_i && reg_addr_i == ADDR_LONG_CTL;
  wire wr_rs = reg_wr_i && reg_addr_i == ADDR_RUN_SYNC;
  wire wd_run = reg_wdata_i[BIT_RUN];

  wire pp = shared_r[3:2] == MODE_PINGPONG;
  wire [1:0] edge_sel = shared_r[5:4];

  // software start and stop of each counter, through either control view
  wire sw_short_wr = wr_sc || wr_rs;
  wire sw_short_val = wr_sc ? wd_run : reg_wdata_i[BIT_RS_SHORT];
  wire sw_long_wr = wr_lc || wr_rs;
  wire sw_long_val = wr_lc ? wd_run : reg_wdata_i[BIT_RS_LONG];
  wire sw_short_start = sw_short_wr && sw_short_val && !short_run_r;
  wire sw_long_start = sw_long_wr && sw_long_val && !long_run_r;

  // demodulated input edges, taken from the second synchroniser stage only
  wire rise = dm_s2_r && !dm_prev_r;
  wire fall = !dm_s2_r && dm_prev_r;
  wire sel_edge = (edge_sel[0] && rise) || (edge_sel[1] && fall);

  // short counter
  wire short_tick;
  wire short_active = short_run_r && !short_wait_r;
  wire short_tc = short_active && short_tick && short_cnt_r == RST_BYTE;
  wire long_tc_pp = pp && long_run_r && long_cnt_r == RST_WORD;
  wire short_start = sw_short_start || long_tc_pp;
  wire short_init_lvl = shared_r[BIT_SHORT_INIT];
  wire [7:0] short_load = short_init_lvl ? short_high_hold_r : short_low_hold_r;
  wire [7:0] short_reload = short_out_r ? short_low_hold_r : short_high_hold_r;
  wire short_stop_tc = short_tc && (pp || sc_single_r);

  // long counter
  wire [15:0] long_load = {long_high_hold_r, long_low_hold_r};
  wire long_start = sw_long_start || (pp && short_tc);
  wire capt_mode = long_run_r && !pp;
  wire edge_capt = capt_mode && sel_edge && (long_armed_r || !lc_single_r);
  wire to_capt = capt_mode && lc_single_r && short_tc;
  wire long_zero = capt_mode && long_cnt_r == RST_WORD && !edge_capt;
  wire lc_rearm = wr_lc && reg_wdata_i[BIT_SINGLE] && !lc_single_r;
  wire short_capt_ev = short_active && sel_edge;

  // flags: hardware set wins over a same-cycle software clear
  wire short_to_set = short_tc;
  wire long_to_set = long_zero || long_tc_pp;
  wire short_to_nxt = short_to_set || (short_to_r && !(wr_sc && reg_wdata_i[BIT_TIMEOUT]));
  wire long_to_nxt = long_to_set || (long_to_r && !(wr_lc && reg_wdata_i[BIT_TIMEOUT]));

  wire short_irq_nxt = (short_tc && sc_tcie_r) || (short_capt_ev && sc_capie_r); // RULE1 RULE11
  wire long_irq_nxt = (long_to_set && lc_toie_r) || ((edge_capt || to_capt) && lc_capie_r); // RULE4 RULE6

  // read mux
  wire [7:0] rd_sc = {short_run_r, sc_single_r, short_to_r, sc_presc_r, sc_capie_r,
                      sc_tcie_r, 1'b0};
  wire [7:0] rd_lc = {long_run_r, lc_single_r, long_to_r, 2'h0, lc_capie_r, lc_toie_r, 1'b0};
  wire [7:0] rd_rs = {RSV_ONES, sync_r, short_run_r, long_run_r}; // RULE17
  wire [7:0] rdata_nxt =
    (reg_addr_i == ADDR_SHORT_CTL) ? rd_sc :
    (reg_addr_i == ADDR_SHARED_CTL) ? {2'h0, shared_r} :
    (reg_addr_i == ADDR_LONG_CTL) ? rd_lc :
    (reg_addr_i == ADDR_RUN_SYNC) ? rd_rs :
    (reg_addr_i == ADDR_SHORT_LO) ? short_low_hold_r :
    (reg_addr_i == ADDR_SHORT_HI) ? short_high_hold_r :
    (reg_addr_i == ADDR_LONG_LO) ? long_low_hold_r :
    (reg_addr_i == ADDR_LONG_HI) ? long_high_hold_r :
    (reg_addr_i == ADDR_CAPT_LO) ? long_cap_r[7:0] :
    (reg_addr_i == ADDR_CAPT_HI) ? long_cap_r[15:8] : RST_BYTE;

  dcpt_prescaler #(
    .DIV_W(3)
  ) u_presc (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .sel_i(sc_presc_r),
    .restart_i(short_start),
    .tick_o(short_tick)
  ); // RULE2

  // configuration registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sc_single_r <= 1'b0;
      sc_presc_r <= 2'h0;
      sc_capie_r <= 1'b0;
      sc_tcie_r <= 1'b0;
      shared_r <= 6'h00;
      lc_single_r <= 1'b0;
      lc_capie_r <= 1'b0;
      lc_toie_r <= 1'b0;
      sync_r <= 1'b0; // RULE18
      short_high_hold_r <= RST_BYTE;
      short_low_hold_r <= RST_BYTE;
      long_high_hold_r <= RST_BYTE;
      long_low_hold_r <= RST_BYTE;
    end else begin
      if (wr_sc) begin
        sc_single_r <= reg_wdata_i[BIT_SINGLE]; // RULE21
        sc_presc_r <= reg_wdata_i[BIT_PRESC_HI:BIT_PRESC_LO];
        sc_capie_r <= reg_wdata_i[BIT_CAPIE];
        sc_tcie_r <= reg_wdata_i[BIT_TCIE];
      end
      if (wr_sh) begin
        shared_r <= reg_wdata_i[5:0]; // RULE12
      end
      if (wr_lc) begin
        lc_single_r <= reg_wdata_i[BIT_SINGLE];
        lc_capie_r <= reg_wdata_i[BIT_CAPIE];
        lc_toie_r <= reg_wdata_i[BIT_TCIE];
      end
      if (wr_rs) begin
        sync_r <= reg_wdata_i[BIT_SYNC];
      end
      if (reg_wr_i && reg_addr_i == ADDR_SHORT_LO) begin
        short_low_hold_r <= reg_wdata_i; // RULE20
      end
      if (reg_wr_i && reg_addr_i == ADDR_SHORT_HI) begin
        short_high_hold_r <= reg_wdata_i; // RULE20
      end
      if (reg_wr_i && reg_addr_i == ADDR_LONG_LO) begin
        long_low_hold_r <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == ADDR_LONG_HI) begin
        long_high_hold_r <= reg_wdata_i;
      end
    end
  end

  // short counter: carrier generation and ping-pong first half
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      short_run_r <= 1'b0; // RULE23
      short_to_r <= 1'b0;
      short_cnt_r <= RST_BYTE;
      short_out_r <= 1'b0;
      short_wait_r <= 1'b0;
    end else begin
      short_to_r <= short_to_nxt; // RULE22
      if (short_start) begin
        short_run_r <= 1'b1; // RULE23 RULE10
        short_out_r <= short_init_lvl; // RULE8
        short_cnt_r <= short_load; // RULE8 RULE15
        short_wait_r <= sync_r; // RULE16
      end else if (sw_short_wr && !sw_short_val) begin
        short_run_r <= 1'b0; // RULE23
        short_wait_r <= 1'b0;
      end else if (short_wait_r) begin
        // hold the first pulse until the demodulated edge so it comes out whole
        if (sel_edge) begin
          short_wait_r <= 1'b0; // RULE16
        end
      end else if (short_tc) begin
        if (short_stop_tc) begin
          short_run_r <= 1'b0; // RULE9 RULE21
        end else begin
          short_out_r <= !short_out_r;
          short_cnt_r <= short_reload;
        end
      end else if (short_active && short_tick) begin
        short_cnt_r <= short_cnt_r - 8'h01;
      end
    end
  end

  // long counter: capture/demodulation and ping-pong second half
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      long_run_r <= 1'b0;
      long_to_r <= 1'b0;
      long_cnt_r <= RST_WORD;
      long_out_r <= 1'b0;
      long_armed_r <= 1'b0;
      long_cap_r <= RST_WORD;
    end else begin
      long_to_r <= long_to_nxt; // RULE6
      if (lc_rearm) begin
        long_armed_r <= 1'b1; // RULE5
      end else if (edge_capt && lc_single_r) begin
        long_armed_r <= 1'b0; // RULE3 RULE5
      end
      if (long_start) begin
        long_run_r <= 1'b1; // RULE9
        long_cnt_r <= long_load; // RULE9 RULE15
        if (pp) begin
          long_out_r <= shared_r[BIT_LONG_INIT]; // RULE9
        end
        if (sw_long_start) begin
          long_armed_r <= 1'b1;
        end
      end else if (sw_long_wr && !sw_long_val) begin
        long_run_r <= 1'b0;
      end else if (long_tc_pp) begin
        long_run_r <= 1'b0; // RULE10
      end else if (edge_capt) begin
        long_cap_r <= long_cnt_r; // RULE5
        long_cnt_r <= long_load;
      end else if (long_run_r) begin
        if (to_capt) begin
          long_cap_r <= long_cnt_r; // RULE4
        end
        // decrement past zero lands on all ones
        long_cnt_r <= long_cnt_r - 16'h0001; // RULE3 RULE6
      end
    end
  end

  // pin synchroniser, interrupt pulses and read data
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dm_s1_r <= 1'b0;
      dm_s2_r <= 1'b0;
      dm_prev_r <= 1'b0;
      short_irq_r <= 1'b0;
      long_irq_r <= 1'b0;
      rdata_r <= RST_BYTE;
    end else begin
      dm_s1_r <= demod_in_i;
      dm_s2_r <= dm_s1_r;
      dm_prev_r <= dm_s2_r;
      short_irq_r <= short_irq_nxt; // RULE19
      long_irq_r <= long_irq_nxt; // RULE19
      if (reg_rd_i) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign reg_rdata_o = rdata_r;
  assign short_output_pin_o = short_out_r;
  assign long_output_pin_o = long_out_r;
  assign short_counter_irq_o = short_irq_r;
  assign long_counter_irq_o = long_irq_r;

  a_short_tc_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE21
    short_stop_tc && !short_start |=> !short_run_r)
    else $error("short counter kept running after single-pass end");
  a_pp_handover: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE9
    pp && short_tc && !sw_long_wr |=> long_run_r && long_out_r == $past(shared_r[0])
      && long_cnt_r == $past(long_load))
    else $error("ping-pong hand-over to long counter wrong");
  a_pp_return: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE10
    long_tc_pp && !sw_long_start |=> short_run_r && !long_run_r
      && short_cnt_r == $past(short_load))
    else $error("ping-pong return to short counter wrong");
  a_long_wrap: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE6
    long_zero && !sw_long_wr |=> long_cnt_r == WRAP_WORD && long_to_r)
    else $error("long counter did not wrap to all ones");
  a_rsv_ones: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE17
    reg_rd_i && reg_addr_i == ADDR_RUN_SYNC |=> reg_rdata_o[7:3] == RSV_ONES)
    else $error("run/sync reserved bits not ones");
  a_restart_load: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE15
    sw_short_start |=> short_cnt_r == $past(short_load) && short_run_r)
    else $error("short restart did not reload");
  a_edge_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE3
    capt_mode && lc_single_r && !long_armed_r && !lc_rearm && sel_edge && !sw_long_wr
      |=> long_cnt_r == $past(long_cnt_r) - 16'h0001)
    else $error("disarmed long counter reacted to an edge");
  a_irq_short: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE11
    short_tc && sc_tcie_r |=> short_counter_irq_o ##1 !short_counter_irq_o || $past(short_irq_nxt))
    else $error("short terminal-count interrupt missing");
  a_sync_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE16
    short_wait_r && !sel_edge && !short_start && short_run_r |=> $stable(short_cnt_r))
    else $error("short counter ran before sync edge");
  a_flag_set_wins: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RULE22
    short_tc |=> short_to_r)
    else $error("short timeout flag lost");
endmodule // dcpt_timer
`default_nettype wire

//--- dv/dcpt_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// stand-in for the core side: register strobes and the demodulated carrier pin
module dcpt_core_model
  import dcpt_pkg::*;
(
  // clock
  input wire logic clk_i,
  // register bank port
  output logic [3:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  // carrier pin
  output logic demod_o
);
  initial begin
    reg_addr_o = 4'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
    demod_o = 1'b0;
  end
  // strobe drops for one edge so back-to-back calls never reassign it in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int len);
    demod_o <= 1'b1;
    repeat (len) @(posedge clk_i);
    demod_o <= 1'b0;
    @(posedge clk_i);
  endtask
  // counters stopped and flags cleared first; a hold of 1 is never programmed
  task automatic start_pingpong(input logic [1:0] levels, input logic [7:0] sh,
                                input logic [15:0] lh);
    logic [7:0] s;
    logic [15:0] l;
    s = (sh == 8'h01) ? 8'h02 : sh;
    l = (lh == 16'h0001) ? 16'h0002 : lh;
    wr(ADDR_SHORT_CTL, 8'h20);
    wr(ADDR_LONG_CTL, 8'h20);
    wr(ADDR_SHORT_LO, s);
    wr(ADDR_SHORT_HI, s);
    wr(ADDR_LONG_LO, l[7:0]);
    wr(ADDR_LONG_HI, l[15:8]);
    wr(ADDR_SHORT_CTL, 8'h42);
    wr(ADDR_LONG_CTL, 8'h42);
    wr(ADDR_SHARED_CTL, {4'h0, MODE_PINGPONG, levels});
    wr(ADDR_SHORT_CTL, 8'hC2);
  endtask
endmodule // dcpt_core_model
`default_nettype wire

//--- dv/dual_counter_pingpong_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
module dual_counter_pingpong_timer_test;
  import dcpt_pkg::*;
  logic clk_i;
  logic reset_n_i;
  logic [3:0] reg_addr_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [7:0] reg_wdata_i;
  logic [7:0] reg_rdata_o;
  logic demod_in_i;
  logic short_output_pin_o;
  logic long_output_pin_o;
  logic long_counter_irq_o;
  logic short_counter_irq_o;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] rnd;
  int err_count = 0;
  int checks = 0;
  int short_irqs = 0;
  int long_irqs = 0;
  int n;
  int t;
  int base;

  dcpt_timer i_dcpt_timer (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .demod_in_i(demod_in_i),
    .short_output_pin_o(short_output_pin_o), .long_output_pin_o(long_output_pin_o),
    .long_counter_irq_o(long_counter_irq_o), .short_counter_irq_o(short_counter_irq_o)
  );
  dcpt_core_model i_dcpt_core_model (
    .clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i), .demod_o(demod_in_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic cmp_range(input string what, input int lo, input int hi, input int s);
    checks++;
    if (s < lo || s > hi) begin
      err_count++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_dcpt_core_model.rd(a);
  endtask
  // returns the cycles waited, or lim when no pulse came
  task automatic wait_irq(input bit long_sel, input int lim, output int cnt);
    int b;
    b = long_sel ? long_irqs : short_irqs;
    cnt = 0;
    while ((long_sel ? long_irqs : short_irqs) == b && cnt < lim) begin
      @(posedge clk_i);
      cnt++;
    end
  endtask

  // read data settles one edge after the strobe; sampled mid-cycle to avoid edge races
  always @(posedge clk_i) rd_seen <= reg_rd_i;
  always @(negedge clk_i) begin
    if (short_counter_irq_o === 1'b1) short_irqs++;
    if (long_counter_irq_o === 1'b1) long_irqs++;
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) cmp_byte("unexpected read", 8'h00, 8'hFF);
      else cmp_byte("read data", exp_q.pop_front(), reg_rdata_o);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    stop_test();
  end

  initial begin
    reset_n_i = 1'b0;
    void'($urandom(32'h7C6AA114));
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(ADDR_SHORT_CTL, 8'h00);
    rd(ADDR_RUN_SYNC, 8'hF8);
    rd(4'hA, 8'h00);
    i_dcpt_core_model.wr(ADDR_RUN_SYNC, 8'h04);
    rd(ADDR_RUN_SYNC, 8'hFC);
    i_dcpt_core_model.wr(ADDR_RUN_SYNC, 8'h00);
    rd(ADDR_RUN_SYNC, 8'hF8);
    rnd = 8'($urandom);
    i_dcpt_core_model.wr(ADDR_SHORT_HI, rnd);
    i_dcpt_core_model.wr(ADDR_SHORT_LO, ~rnd);
    rd(ADDR_SHORT_HI, rnd);
    rd(ADDR_SHORT_LO, ~rnd);
    // single pass at every prescale, then flag write-0 and write-1
    for (int s = 0; s < 4; s++) begin
      rnd = 8'($urandom_range(3, 9));
      t = (int'(rnd) + 1) << s;
      i_dcpt_core_model.wr(ADDR_SHORT_LO, rnd);
      i_dcpt_core_model.wr(ADDR_SHORT_HI, rnd);
      i_dcpt_core_model.wr(ADDR_SHORT_CTL, {3'b110, 2'(s), 3'b010});
      wait_irq(1'b0, 200, n);
      cmp_range("prescaled count", t - 2, t + 3, n);
      rd(ADDR_SHORT_CTL, {3'b011, 2'(s), 3'b010});
      i_dcpt_core_model.wr(ADDR_SHORT_CTL, {3'b010, 2'(s), 3'b010});
      rd(ADDR_SHORT_CTL, {3'b011, 2'(s), 3'b010});
      i_dcpt_core_model.wr(ADDR_SHORT_CTL, {3'b011, 2'(s), 3'b010});
      rd(ADDR_SHORT_CTL, {3'b010, 2'(s), 3'b010});
    end
    // stop mid-count, restart: full count again
    i_dcpt_core_model.wr(ADDR_SHORT_LO, 8'h09);
    i_dcpt_core_model.wr(ADDR_SHORT_HI, 8'h09);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'hC2);
    repeat (5) @(posedge clk_i);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'h42);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'hE2);
    wait_irq(1'b0, 40, n);
    cmp_range("restart count", 8, 13, n);
    // modulo-N keeps running
    i_dcpt_core_model.wr(ADDR_SHORT_LO, 8'h03);
    i_dcpt_core_model.wr(ADDR_SHORT_HI, 8'h03);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'hA2);
    wait_irq(1'b0, 20, n);
    wait_irq(1'b0, 20, n);
    cmp_range("modulo period", 2, 6, n);
    rd(ADDR_SHORT_CTL, 8'hA2);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'h02);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'h20);
    rd(ADDR_SHORT_CTL, 8'h00);
    // long counter passes zero
    i_dcpt_core_model.wr(ADDR_LONG_HI, 8'h00);
    i_dcpt_core_model.wr(ADDR_LONG_LO, 8'h03);
    i_dcpt_core_model.wr(ADDR_LONG_CTL, 8'h82);
    wait_irq(1'b1, 20, n);
    cmp_range("long zero", 2, 8, n);
    rd(ADDR_LONG_CTL, 8'hA2);
    i_dcpt_core_model.wr(ADDR_LONG_CTL, 8'h20);
    rd(ADDR_LONG_CTL, 8'h00);
    // ping-pong with both initial levels high
    i_dcpt_core_model.start_pingpong(2'b11, 8'h14, 16'h001E);
    @(negedge clk_i);
    cmp_byte("short pin", 8'h01, {7'h00, short_output_pin_o});
    @(posedge clk_i);
    wait_irq(1'b0, 60, n);
    cmp_range("short leg", 16, 25, n);
    @(negedge clk_i);
    cmp_byte("long pin", 8'h01, {7'h00, long_output_pin_o});
    @(posedge clk_i);
    rd(ADDR_RUN_SYNC, 8'hF9);
    wait_irq(1'b1, 60, n);
    cmp_range("long leg", 20, 34, n);
    rd(ADDR_RUN_SYNC, 8'hFA);
    wait_irq(1'b0, 60, n);
    cmp_range("short leg again", 10, 24, n);
    wait_irq(1'b1, 60, n);
    i_dcpt_core_model.wr(ADDR_SHARED_CTL, 8'h03);
    base = long_irqs;
    repeat (80) @(posedge clk_i);
    rd(ADDR_RUN_SYNC, 8'hF8);
    cmp_range("long after end", base, base, long_irqs);
    // sync holds the first short pulse until a demod edge
    i_dcpt_core_model.wr(ADDR_SHARED_CTL, 8'h10);
    i_dcpt_core_model.wr(ADDR_SHORT_LO, 8'h02);
    i_dcpt_core_model.wr(ADDR_SHORT_HI, 8'h02);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'h62);
    i_dcpt_core_model.wr(ADDR_RUN_SYNC, 8'h04);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'hC2);
    @(negedge clk_i);
    cmp_byte("short pin", 8'h00, {7'h00, short_output_pin_o});
    wait_irq(1'b0, 30, n);
    cmp_range("sync hold-off", 30, 30, n);
    base = short_irqs;
    i_dcpt_core_model.pulse(4);
    repeat (15) @(posedge clk_i);
    cmp_range("sync release", base + 1, base + 1, short_irqs);
    i_dcpt_core_model.wr(ADDR_RUN_SYNC, 8'h00);
    // capture interrupt on a rising demod edge, then masked
    i_dcpt_core_model.wr(ADDR_SHORT_LO, 8'hFF);
    i_dcpt_core_model.wr(ADDR_SHORT_HI, 8'hFF);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'hBC);
    base = short_irqs;
    i_dcpt_core_model.pulse(4);
    repeat (8) @(posedge clk_i);
    cmp_range("capture irq", base + 1, base + 1, short_irqs);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'h98);
    i_dcpt_core_model.pulse(4);
    repeat (8) @(posedge clk_i);
    cmp_range("masked capture", base + 1, base + 1, short_irqs);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'h20);
    rd(ADDR_SHORT_CTL, 8'h00);
    // long single-pass capture: one armed edge, later edges ignored, re-arm, short timeouts
    i_dcpt_core_model.wr(ADDR_LONG_HI, 8'h00);
    i_dcpt_core_model.wr(ADDR_LONG_LO, 8'hC8);
    base = long_irqs;
    i_dcpt_core_model.wr(ADDR_LONG_CTL, 8'hC4);
    i_dcpt_core_model.pulse(4);
    i_dcpt_core_model.pulse(4);
    rd(ADDR_CAPT_LO, 8'hC5);
    cmp_range("single capture irq", base + 1, base + 1, long_irqs);
    i_dcpt_core_model.wr(ADDR_LONG_CTL, 8'h84);
    i_dcpt_core_model.wr(ADDR_LONG_CTL, 8'hC4);
    i_dcpt_core_model.pulse(4);
    rd(ADDR_CAPT_LO, 8'hB9);
    rd(ADDR_CAPT_HI, 8'h00);
    i_dcpt_core_model.wr(ADDR_SHORT_LO, 8'h03);
    i_dcpt_core_model.wr(ADDR_SHORT_HI, 8'h03);
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'hC2);
    wait_irq(1'b0, 20, n);
    rd(ADDR_CAPT_LO, 8'hBA);
    // a reload at the first timeout would make the second capture read C1h
    i_dcpt_core_model.wr(ADDR_SHORT_CTL, 8'hC2);
    wait_irq(1'b0, 20, n);
    rd(ADDR_CAPT_LO, 8'hB2);
    cmp_range("capture irqs", base + 4, base + 4, long_irqs);
    stop_test();
  end
endmodule // dual_counter_pingpong_timer_test
`default_nettype wire
